// ===== verification/ata_cfg_bank_props.sv
// assertion checker for the drive interface configuration bank
`timescale 1ns/1ps
module ata_cfg_bank_props (
    input wire logic CLK_SYS_I, // clock
    input wire logic RST_I, // reset
    input wire logic USB_RST_I, // usb reset
    input wire logic [15:0] XADDR_I, // address
    input wire logic XWR_I, // write
    input wire logic XRD_I, // read
    input wire logic [7:0] XWDATA_I, // wdata
    input wire logic [31:0] USB_COUNT_I, // count
    input wire logic [31:0] DRIVE_COUNT_I, // count
    input wire logic START_I, // start
    input wire logic PACKET_I, // packet
    input wire logic DIR_MATCH_I, // match
    input wire logic MCU_GO_I, // go
    input wire logic [7:0] XRDATA_O, // rdata
    input wire logic XRVALID_O, // valid
    input wire logic [1:0] PROTO_O, // protocol
    input wire logic DIR_SEQ_ERR_O, // error
    input wire logic WRITE_PENDING_O, // pending
    input wire logic FIFO_MOVE_O, // move
    input wire logic FIFO_FLUSH_O, // flush
    input wire logic XFER_ABORT_O // abort
);
    logic [7:0] cfg;
    logic [7:0] wd_q;
    logic [31:0] cnt_q;
    logic [1:0] a_q;
    wire hit = XADDR_I[15:4] == 12'hF0D;
    // cfg[0] set means one of the two dma protocols
    wire chk = START_I && PACKET_I && cfg[2] && cfg[0];
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I)
            cfg <= 8'h00;
        else if (XWR_I && XADDR_I == 16'hF0D0)
            cfg <= XWDATA_I & 8'h8F;
    end
    always_ff @(posedge CLK_SYS_I) begin
        wd_q <= XWDATA_I;
        a_q <= XADDR_I[1:0] - 2'd2;
        cnt_q <= cfg[7] ? DRIVE_COUNT_I : USB_COUNT_I;
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    a_read_answer: assert property (XRD_I && hit |=> XRVALID_O)
        else $error("read not answered");
    a_cfg_readback: assert property (XRD_I && XADDR_I == 16'hF0D0 |=> XRDATA_O == cfg)
        else $error("config readback wrong");
    a_count_view: assert property (XRD_I && XADDR_I inside {[16'hF0D6:16'hF0D9]}
        |=> XRDATA_O == cnt_q[{a_q, 3'b000} +: 8])
        else $error("count byte wrong");
    a_proto_write: assert property (XWR_I && XADDR_I == 16'hF0D0 |=> PROTO_O == wd_q[1:0])
        else $error("protocol not written");
    a_usb_rst_keep: assert property (USB_RST_I && !XWR_I |=> $stable(PROTO_O))
        else $error("usb reset changed config");
    a_dir_mismatch: assert property (chk && !DIR_MATCH_I |-> ##2 DIR_SEQ_ERR_O && XFER_ABORT_O)
        else $error("mismatch not aborted");
    a_dir_match: assert property (chk && DIR_MATCH_I |-> ##2 FIFO_MOVE_O && !DIR_SEQ_ERR_O)
        else $error("matched transfer not moving");
    a_ata_skip: assert property (START_I && !PACKET_I && !FIFO_MOVE_O && !WRITE_PENDING_O
        |=> FIFO_MOVE_O)
        else $error("plain transfer not moving");
    a_go_flush: assert property (WRITE_PENDING_O && MCU_GO_I && cfg[3]
        |=> FIFO_FLUSH_O && XFER_ABORT_O && !WRITE_PENDING_O)
        else $error("pending write not flushed");
    a_go_drain: assert property (WRITE_PENDING_O && MCU_GO_I && !cfg[3]
        |=> FIFO_MOVE_O && !FIFO_FLUSH_O)
        else $error("pending write not drained");
endmodule // ata_cfg_bank_props
bind ata_interface_config_bank ata_cfg_bank_props ata_cfg_bank_props_inst (.CLK_SYS_I, .RST_I,
    .USB_RST_I, .XADDR_I, .XWR_I, .XRD_I, .XWDATA_I, .USB_COUNT_I, .DRIVE_COUNT_I, .START_I,
    .PACKET_I, .DIR_MATCH_I, .MCU_GO_I, .XRDATA_O, .XRVALID_O, .PROTO_O, .DIR_SEQ_ERR_O,
    .WRITE_PENDING_O, .FIFO_MOVE_O, .FIFO_FLUSH_O, .XFER_ABORT_O);

// ===== verification/ata_interface_config_bank_tb.sv
// self-checking bench for the drive interface configuration bank
`timescale 1ns/1ps
module ata_interface_config_bank_tb;
    logic CLK_SYS_I = 1'b0, RST_I = 1'b1, USB_RST_I = 1'b0, START_I = 1'b0, PACKET_I = 1'b0;
    logic DIR_MATCH_I = 1'b0, USB_MISMATCH_I = 1'b0, FIFO_EMPTY_I = 1'b0, MCU_GO_I = 1'b0;
    logic [7:0] CONFIG1_I = 8'h5A, ACC2_STATUS_I = 8'hC3, ACC3_STATUS_I = 8'h3C;
    logic [31:0] USB_COUNT_I = 32'h1234_5678, DRIVE_COUNT_I = 32'h9ABC_DEF0;
    logic [15:0] XADDR_I;
    logic XWR_I, XRD_I, XRVALID_O, DIR_SEQ_ERR_O, WRITE_PENDING_O;
    logic FIFO_MOVE_O, FIFO_FLUSH_O, XFER_ABORT_O, v;
    logic [7:0] XWDATA_I, XRDATA_O, ACC0_O, ACC1_O, CMD_LEN_O, SECTOR_COUNT_O, d;
    logic [7:0] PIO_ASSERT_O, PIO_RECOVERY_O, DMA_ASSERT_O, DMA_RECOVERY_O;
    logic [1:0] PROTO_O;
    logic [7:0] mir [16];
    int num_errors = 0, num_checks = 0;
    always #50 CLK_SYS_I = ~CLK_SYS_I;
    ata_interface_config_bank ata_interface_config_bank_inst (.CLK_SYS_I, .RST_I, .USB_RST_I,
        .XADDR_I, .XWR_I, .XRD_I, .XWDATA_I, .USB_COUNT_I, .DRIVE_COUNT_I, .CONFIG1_I,
        .ACC2_STATUS_I, .ACC3_STATUS_I, .START_I, .PACKET_I, .DIR_MATCH_I, .USB_MISMATCH_I,
        .FIFO_EMPTY_I, .MCU_GO_I, .XRDATA_O, .XRVALID_O, .ACC0_O, .ACC1_O, .PROTO_O,
        .CMD_LEN_O, .SECTOR_COUNT_O, .PIO_ASSERT_O, .PIO_RECOVERY_O, .DMA_ASSERT_O,
        .DMA_RECOVERY_O, .DIR_SEQ_ERR_O, .WRITE_PENDING_O, .FIFO_MOVE_O, .FIFO_FLUSH_O,
        .XFER_ABORT_O);
    mcu_fw_model mcu_fw_model_inst (.clk_i(CLK_SYS_I), .rdata_i(XRDATA_O), .rvalid_i(XRVALID_O),
        .addr_o(XADDR_I), .wr_o(XWR_I), .rd_o(XRD_I), .wdata_o(XWDATA_I));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [7:0] exp_rd(input int o);
        logic [31:0] c;
        c = mir[0][7] ? DRIVE_COUNT_I : USB_COUNT_I;
        case (o)
            1: return CONFIG1_I;
            4: return ACC2_STATUS_I;
            5: return ACC3_STATUS_I;
            6, 7, 8, 9: return c[(o - 6) * 8 +: 8];
            default: return mir[o];
        endcase
    endfunction
    task automatic sweep();
        for (int o = 0; o < 16; o++) begin
            mcu_fw_model_inst.rd(16'hF0D0 + 16'(o), d, v);
            check(v, 1'b1);
            check(d, exp_rd(o));
        end
    endtask
    task automatic put(input int o, input logic [7:0] x);
        mcu_fw_model_inst.wr(16'hF0D0 + 16'(o), x);
        if (o == 0)
            mir[0] = x & 8'h8F;
        else if (!(o inside {1, [4:9]}))
            mir[o] = x;
    endtask
    task automatic do_reset();
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        foreach (mir[i]) mir[i] = 8'h00;
    endtask
    task automatic go(input logic pk, input logic m, input int lat, input logic err);
        PACKET_I <= pk;
        DIR_MATCH_I <= m;
        START_I <= 1'b1;
        @(posedge CLK_SYS_I);
        START_I <= 1'b0;
        repeat (lat) @(posedge CLK_SYS_I);
        check({DIR_SEQ_ERR_O, XFER_ABORT_O, FIFO_MOVE_O}, {err, err, !err});
    endtask
    task automatic drain();
        FIFO_EMPTY_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        FIFO_EMPTY_I <= 1'b0;
        @(posedge CLK_SYS_I);
        check(FIFO_MOVE_O, 1'b0);
    endtask
    initial begin
        repeat (5000) @(posedge CLK_SYS_I);
        num_errors++;
        end_sim();
    end
    initial begin
        do_reset();
        sweep();
        for (int o = 0; o < 16; o++) put(o, ~8'(o));
        // last write lands on the edge put returns at; let it settle first
        @(posedge CLK_SYS_I);
        check({ACC0_O, ACC1_O, CMD_LEN_O, SECTOR_COUNT_O}, {mir[2], mir[3], mir[10], mir[11]});
        check({PIO_ASSERT_O, PIO_RECOVERY_O, DMA_ASSERT_O, DMA_RECOVERY_O},
            {mir[12], mir[13], mir[14], mir[15]});
        check(PROTO_O, mir[0][1:0]);
        sweep();
        mcu_fw_model_inst.rd(16'hF0CF, d, v);
        check({v, d}, 9'h000);
        mcu_fw_model_inst.rd(16'hF0E0, d, v);
        check({v, d}, 9'h000);
        $display("test register map done");
        mcu_fw_model_inst.view(1'b0);
        mcu_fw_model_inst.rd(16'hF0D9, d, v);
        check(d, USB_COUNT_I[31:24]);
        USB_RST_I <= 1'b1;
        @(posedge CLK_SYS_I);
        USB_RST_I <= 1'b0;
        mcu_fw_model_inst.rd(16'hF0D0, d, v);
        check(d, 8'h0F);
        $display("test view and usb reset done");
        for (int p = 0; p < 4; p++) begin
            put(0, 8'h04 | 8'(p));
            go(1'b1, 1'b0, p[0] ? 2 : 1, p[0]);
            drain();
        end
        put(0, 8'h05);
        go(1'b1, 1'b1, 2, 1'b0);
        drain();
        put(0, 8'h07);
        go(1'b0, 1'b0, 1, 1'b0);
        drain();
        $display("test direction check done");
        for (int a = 0; a < 2; a++) begin
            go(1'b0, 1'b0, 1, 1'b0);
            USB_MISMATCH_I <= 1'b1;
            @(posedge CLK_SYS_I);
            USB_MISMATCH_I <= 1'b0;
            repeat (2) @(posedge CLK_SYS_I);
            check({WRITE_PENDING_O, FIFO_MOVE_O}, 2'b10);
            put(0, 8'(a * 8));
            MCU_GO_I <= 1'b1;
            @(posedge CLK_SYS_I);
            MCU_GO_I <= 1'b0;
            @(posedge CLK_SYS_I);
            check({WRITE_PENDING_O, FIFO_FLUSH_O, XFER_ABORT_O, FIFO_MOVE_O},
                a ? 4'b0110 : 4'b0001);
            drain();
        end
        $display("test write pending done");
        put(0, 8'h8F);
        do_reset();
        check(PROTO_O, 2'b00);
        sweep();
        $display("test mid-run reset done");
        end_sim();
    end
endmodule // ata_interface_config_bank_tb

// ===== verification/mcu_fw_model.sv
// firmware model: mcu master on the external data space
`timescale 1ns/1ps
module mcu_fw_model (
    input wire logic clk_i, // clock
    input wire logic [7:0] rdata_i, // rdata
    input wire logic rvalid_i, // valid
    output logic [15:0] addr_o = 16'h0000, // address
    output logic wr_o = 1'b0, // write
    output logic rd_o = 1'b0, // read
    output logic [7:0] wdata_o = 8'h00 // wdata
);
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d; // stale data not left on the bus
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
        v = rvalid_i;
    endtask
    task automatic view(input logic b);
        logic [7:0] d;
        logic v;
        rd(16'hF0D0, d, v);
        wr(16'hF0D0, {b, d[6:0]});
    endtask
endmodule // mcu_fw_model

// ===== verilog/ata_cfg_bus_if.sv
// bus between register decode and the transfer policy unit
`timescale 1ns/1ps
interface ata_cfg_bus_if;
    logic [1:0] proto;
    logic dir_check_en;
    logic wp_abort_en;
    logic start;
    logic is_packet;
    logic dir_match;
    logic usb_count_mismatch;
    logic fifo_empty;
    logic mcu_go;
    logic pend;
    logic dir_err;
    logic flush;
    logic move;
    logic abort;
    modport ctrl (input proto, dir_check_en, wp_abort_en, start, is_packet, dir_match,
        usb_count_mismatch, fifo_empty, mcu_go, output pend, dir_err, flush, move, abort);
    modport bank (output proto, dir_check_en, wp_abort_en, start, is_packet, dir_match,
        usb_count_mismatch, fifo_empty, mcu_go, input pend, dir_err, flush, move, abort);
endinterface

// ===== verilog/ata_cfg_map.svh
// register map constants for the drive interface configuration bank
`ifndef ATA_CFG_MAP_SVH
`define ATA_CFG_MAP_SVH
`define BANK_BASE 16'hF0C0
`define OFF_CFG0 5'h10
`define OFF_CFG1 5'h11
`define OFF_ACC0 5'h12
`define OFF_ACC1 5'h13
`define OFF_ACC2 5'h14
`define OFF_ACC3 5'h15
`define OFF_CNT0 5'h16
`define OFF_CNT1 5'h17
`define OFF_CNT2 5'h18
`define OFF_CNT3 5'h19
`define OFF_CMDLEN 5'h1A
`define OFF_SECCNT 5'h1B
`define OFF_PIO_AST 5'h1C
`define OFF_PIO_REC 5'h1D
`define OFF_DMA_AST 5'h1E
`define OFF_DMA_REC 5'h1F
`define BIT_VIEW_SEL 7
`define BIT_WP_ABORT 3
`define BIT_DIR_CHECK 2
`define CFG0_WR_MASK 8'h8F
`define REG_RESET 8'h00
`define PROTO_PIO 2'b00
`define PROTO_MDMA 2'b01
`define PROTO_UDMA 2'b11
`endif

// ===== verilog/ata_cfg_pkg.sv
// types for the drive interface configuration bank
package ata_cfg_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_RUN = 4'b0100,
        ST_PEND = 4'b1000
    } xfer_state_e;
    typedef logic [7:0] byte_t;
endpackage

// ===== verilog/ata_interface_config_bank.sv
// drive interface group-1 configuration register bank
// ---------------------------------------------------------------
// Notes on behaviour
// - sixteen byte registers at offsets 10h-1Fh above base F0C0.
// - 32-bit byte count at 16h-19h, least significant byte lowest.
// - power-up or watchdog reset clears configuration register 0.
// - usb bus reset leaves configuration register 0 untouched.
// - bit 7 picks usb count (0) or drive count (1) for reads.
// - bits 1:0 pick pio, multiword dma, ultra dma; 10 reserved.
// - bit 2 enables direction check before packet dma transfers.
// - direction mismatch aborts transfer and sets direction error flag.
// - direction check is ignored for plain ata transfers.
// - usb count mismatch on write pauses fifo draining until mcu decides.
// - bit 3 set: mcu may abort and flush the last packet.
// - bit 3 clear: fifo drains to drive up to the wrapper length.
// - pio and dma assertion/recovery timing registers at 1Ch-1Fh.
// - command length at 1Ah, block sector count at 1Bh.
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "ata_cfg_map.svh"
module ata_interface_config_bank
    import ata_cfg_pkg::*;
(
    input wire logic CLK_SYS_I, // 10 MHz system clock
    input wire logic RST_I, // power-up or watchdog reset, high
    input wire logic USB_RST_I, // usb bus reset, ignored by the bank
    input wire logic [15:0] XADDR_I, // mcu external data address
    input wire logic XWR_I, // write strobe, one cycle
    input wire logic XRD_I, // read strobe, one cycle
    input wire logic [7:0] XWDATA_I, // write data
    input wire logic [31:0] USB_COUNT_I, // usb-side byte count
    input wire logic [31:0] DRIVE_COUNT_I, // drive-side byte count
    input wire logic [7:0] CONFIG1_I, // config register 1 view
    input wire logic [7:0] ACC2_STATUS_I, // access reg 2 view
    input wire logic [7:0] ACC3_STATUS_I, // access reg 3 view
    input wire logic START_I, // data stage start pulse
    input wire logic PACKET_I, // drive uses packet protocol
    input wire logic DIR_MATCH_I, // bridge and drive dma direction agree
    input wire logic USB_MISMATCH_I, // usb byte count mismatch on write
    input wire logic FIFO_EMPTY_I, // sector fifo drained
    input wire logic MCU_GO_I, // mcu decision on pending write
    output logic [7:0] XRDATA_O, // read data
    output logic XRVALID_O, // read data valid
    output logic [7:0] ACC0_O, // access reg 0
    output logic [7:0] ACC1_O, // access reg 1
    output logic [1:0] PROTO_O, // transfer protocol select
    output logic [7:0] CMD_LEN_O, // command length
    output logic [7:0] SECTOR_COUNT_O, // block sector count
    output logic [7:0] PIO_ASSERT_O, // pio assertion time
    output logic [7:0] PIO_RECOVERY_O, // pio recovery time
    output logic [7:0] DMA_ASSERT_O, // dma assertion time
    output logic [7:0] DMA_RECOVERY_O, // dma recovery time
    output logic DIR_SEQ_ERR_O, // direction error pulse to interrupt reg 1
    output logic WRITE_PENDING_O, // write paused for mcu
    output logic FIFO_MOVE_O, // fifo to drive moving
    output logic FIFO_FLUSH_O, // flush last packet, pulse
    output logic XFER_ABORT_O // transfer abort, pulse
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        byte_t cfg0;
        byte_t acc0;
        byte_t acc1;
        byte_t cmd_len;
        byte_t sec_cnt;
        byte_t pio_ast;
        byte_t pio_rec;
        byte_t dma_ast;
        byte_t dma_rec;
        byte_t rdata;
        logic rvalid;
    } bank_s;
    bank_s q;
    bank_s next_q;
    logic hit;
    logic [4:0] off;
    logic [31:0] count_view;
    byte_t rd_mux;
    logic [1:0] cnt_idx;
    ata_cfg_bus_if pol_bus();

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    // upper half of the 32-byte window only; lower half is the task file
    assign hit = (XADDR_I[15:5] == `BANK_BASE >> 5) && XADDR_I[4];
    assign off = XADDR_I[4:0];
    assign count_view = q.cfg0[`BIT_VIEW_SEL] ? DRIVE_COUNT_I : USB_COUNT_I;
    assign cnt_idx = off[1:0] - 2'b10;

    always_comb begin
        rd_mux = `REG_RESET;
        if (off == `OFF_CFG0) begin
            rd_mux = q.cfg0;
        end else if (off == `OFF_CFG1) begin
            rd_mux = CONFIG1_I;
        end else if (off == `OFF_ACC0) begin
            rd_mux = q.acc0;
        end else if (off == `OFF_ACC1) begin
            rd_mux = q.acc1;
        end else if (off == `OFF_ACC2) begin
            rd_mux = ACC2_STATUS_I;
        end else if (off == `OFF_ACC3) begin
            rd_mux = ACC3_STATUS_I;
        end else if (off >= `OFF_CNT0 && off <= `OFF_CNT3) begin
            rd_mux = count_view[cnt_idx*8 +: 8];
        end else if (off == `OFF_CMDLEN) begin
            rd_mux = q.cmd_len;
        end else if (off == `OFF_SECCNT) begin
            rd_mux = q.sec_cnt;
        end else if (off == `OFF_PIO_AST) begin
            rd_mux = q.pio_ast;
        end else if (off == `OFF_PIO_REC) begin
            rd_mux = q.pio_rec;
        end else if (off == `OFF_DMA_AST) begin
            rd_mux = q.dma_ast;
        end else if (off == `OFF_DMA_REC) begin
            rd_mux = q.dma_rec;
        end
    end

    // ---------------------------------------------------------------
    // register update
    // ---------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.rvalid = XRD_I && hit;
        next_q.rdata = (XRD_I && hit) ? rd_mux : `REG_RESET;
        if (XWR_I && hit) begin
            if (off == `OFF_CFG0) begin
                // reserved bits 6:4 stay zero whatever is written
                next_q.cfg0 = XWDATA_I & `CFG0_WR_MASK;
            end else if (off == `OFF_ACC0) begin
                next_q.acc0 = XWDATA_I;
            end else if (off == `OFF_ACC1) begin
                next_q.acc1 = XWDATA_I;
            end else if (off == `OFF_CMDLEN) begin
                next_q.cmd_len = XWDATA_I;
            end else if (off == `OFF_SECCNT) begin
                next_q.sec_cnt = XWDATA_I;
            end else if (off == `OFF_PIO_AST) begin
                next_q.pio_ast = XWDATA_I;
            end else if (off == `OFF_PIO_REC) begin
                next_q.pio_rec = XWDATA_I;
            end else if (off == `OFF_DMA_AST) begin
                next_q.dma_ast = XWDATA_I;
            end else if (off == `OFF_DMA_REC) begin
                next_q.dma_rec = XWDATA_I;
            end
        end
    end

    // usb reset deliberately not wired into this process
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ---------------------------------------------------------------
    // transfer policy
    // ---------------------------------------------------------------
    assign pol_bus.proto = q.cfg0[1:0];
    assign pol_bus.dir_check_en = q.cfg0[`BIT_DIR_CHECK];
    assign pol_bus.wp_abort_en = q.cfg0[`BIT_WP_ABORT];
    assign pol_bus.start = START_I;
    assign pol_bus.is_packet = PACKET_I;
    assign pol_bus.dir_match = DIR_MATCH_I;
    assign pol_bus.usb_count_mismatch = USB_MISMATCH_I;
    assign pol_bus.fifo_empty = FIFO_EMPTY_I;
    assign pol_bus.mcu_go = MCU_GO_I;

    ata_xfer_policy ata_xfer_policy_inst (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .bus(pol_bus.ctrl)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign XRDATA_O = q.rdata;
    assign XRVALID_O = q.rvalid;
    assign ACC0_O = q.acc0;
    assign ACC1_O = q.acc1;
    assign PROTO_O = q.cfg0[1:0];
    assign CMD_LEN_O = q.cmd_len;
    assign SECTOR_COUNT_O = q.sec_cnt;
    assign PIO_ASSERT_O = q.pio_ast;
    assign PIO_RECOVERY_O = q.pio_rec;
    assign DMA_ASSERT_O = q.dma_ast;
    assign DMA_RECOVERY_O = q.dma_rec;
    assign DIR_SEQ_ERR_O = pol_bus.dir_err;
    assign WRITE_PENDING_O = pol_bus.pend;
    assign FIFO_MOVE_O = pol_bus.move;
    assign FIFO_FLUSH_O = pol_bus.flush;
    assign XFER_ABORT_O = pol_bus.abort;
endmodule // ata_interface_config_bank

// ===== verilog/ata_xfer_policy.sv
// transfer policy: direction check and write-pending handling
`timescale 1ns/1ps
module ata_xfer_policy
    import ata_cfg_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // async reset, high
    ata_cfg_bus_if.ctrl bus // policy controls and events
);
    typedef struct packed {
        xfer_state_e st;
        logic pend;
        logic dir_err;
        logic flush;
        logic move;
        logic abort;
    } pol_s;
    pol_s q;
    pol_s next_q;
    logic is_dma;

    assign is_dma = (bus.proto == `PROTO_MDMA) || (bus.proto == `PROTO_UDMA);

    always_comb begin
        next_q = q;
        next_q.dir_err = 1'b0;
        next_q.flush = 1'b0;
        next_q.abort = 1'b0;
        case (q.st)
            ST_IDLE: begin
                if (bus.start) begin
                    // only packet-protocol dma is checked; plain ata skips it
                    if (bus.dir_check_en && bus.is_packet && is_dma) begin
                        next_q.st = ST_CHECK;
                    end else begin
                        next_q.st = ST_RUN;
                        next_q.move = 1'b1;
                    end
                end
            end
            ST_CHECK: begin
                if (bus.dir_match) begin
                    next_q.st = ST_RUN;
                    next_q.move = 1'b1;
                end else begin
                    next_q.st = ST_IDLE;
                    next_q.abort = 1'b1;
                    next_q.dir_err = 1'b1;
                end
            end
            ST_RUN: begin
                if (bus.usb_count_mismatch) begin
                    next_q.st = ST_PEND;
                    next_q.move = 1'b0;
                    next_q.pend = 1'b1;
                end else if (bus.fifo_empty) begin
                    next_q.st = ST_IDLE;
                    next_q.move = 1'b0;
                end
            end
            ST_PEND: begin
                // policy bit is sampled when the mcu releases the pause
                if (bus.mcu_go) begin
                    next_q.pend = 1'b0;
                    if (bus.wp_abort_en) begin
                        next_q.st = ST_IDLE;
                        next_q.flush = 1'b1;
                        next_q.abort = 1'b1;
                    end else begin
                        next_q.st = ST_RUN;
                        next_q.move = 1'b1;
                    end
                end
            end
            default: next_q.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{st: ST_IDLE, default: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign bus.pend = q.pend;
    assign bus.dir_err = q.dir_err;
    assign bus.flush = q.flush;
    assign bus.move = q.move;
    assign bus.abort = q.abort;
endmodule // ata_xfer_policy
